// file: ptp_trig_pkg.sv
// constants for the unit 1 target-time trigger block and its register map
// Behaviour
// - bits 10-8 delay unit 1; 1 ns/4 ns steps
// - byte extends unit 12 pulse width bits 23-16
// - 30-bit target nanoseconds; top two bits read zero
// - 32-bit target seconds in two words, reset zero
// - config bit 15 selects cascade mode, reset zero
// - enables self-clear on output; software sets head only
// - done flag on notified event, write-one clears, interrupts
// - no tail in cascade: loop until soft reset
package ptp_trig_pkg;
  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_DONE = 10'h204;
  localparam logic [9:0] IDX_EN = 10'h206;
  localparam logic [9:0] IDX_SWRST = 10'h208;
  localparam logic [9:0] IDX_PPS_SKEW = 10'h20a;
  localparam logic [9:0] IDX_NSL = 10'h220;
  localparam logic [9:0] IDX_NSH = 10'h222;
  localparam logic [9:0] IDX_SL = 10'h224;
  localparam logic [9:0] IDX_SH = 10'h226;
  localparam logic [9:0] IDX_CFG1 = 10'h228;
  localparam logic [9:0] IDX_U12_CFG2 = 10'h38a;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h230;
  // ----------------------------------------------------------------
  // field layouts
  // ----------------------------------------------------------------
  localparam int UNITS = 12;
  localparam int CFG_CASCADE_BIT = 15;
  localparam int CFG_TAIL_BIT = 14;
  localparam int CFG_NOTIFY_BIT = 13;
  localparam int SKEW_LSB = 8;
  localparam int SKEW_FINE_BIT = 11;
  localparam logic [15:0] PPS_SKEW_MASK = 16'h0fff;
  localparam logic [15:0] NSH_MASK = 16'h3fff;
  localparam logic [15:0] CFG1_MASK = 16'he000;
  localparam logic [15:0] UNIT_MASK = 16'h0fff;
  localparam logic [15:0] RST_WORD = 16'h0000;
  // ----------------------------------------------------------------
  // timing: compensation step per code and nanoseconds per second, in ns
  // ----------------------------------------------------------------
  localparam logic [30:0] STEP_FINE_NS = 31'h1;
  localparam logic [30:0] STEP_COARSE_NS = 31'h4;
  localparam logic [30:0] NS_PER_SEC = 31'h3b9aca00;
  // ----------------------------------------------------------------
  // bus encodings and unit 1 sequencer states
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
  typedef enum logic [1:0] {UNIT_IDLE, UNIT_ARMED, UNIT_WAIT_LOW} unit_state_t;
endpackage

// file: ptp_trigger_target_time.sv
// unit 1 target-time trigger with its registers behind an AHB-Lite slave
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ps
module ptp_trigger_target_time (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [31:0] PTP_SEC,
  input wire logic [29:0] PTP_NS,
  input wire logic [ptp_trig_pkg::UNITS-1:0] UNIT_EVENT,
  output logic TRIG1_OUT,
  output logic [ptp_trig_pkg::UNITS-1:0] TRIGGER_UNIT_ENABLES_OUT,
  output logic [ptp_trig_pkg::UNITS-1:0] SW_RST_OUT,
  output logic [23:0] PPS12_WIDTH,
  output logic IRQ
);
  import ptp_trig_pkg::*;

  // ----------------------------------------------------------------
  // bus slave: address phase capture
  // ----------------------------------------------------------------
  logic wr_pend_reg, wr_pend_next;
  logic [9:0] wr_idx_reg, wr_idx_next;
  logic addr_ok;
  logic [9:0] a_idx;
  logic wr_now;
  logic [9:0] w_idx;
  logic [15:0] wd;

  assign a_idx = HADDR[11:2];
  assign addr_ok = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ) && (HADDR[31:12] == 20'h0);
  assign wr_now = wr_pend_reg;
  assign w_idx = wr_idx_reg;
  assign wd = HWDATA[15:0];
  // zero wait states: each transfer finishes in the data phase right after its address phase
  assign HREADYOUT = 1'b1;
  assign HRESP = HRESP_OKAY;

  always_comb begin
    wr_pend_next = addr_ok && HWRITE;
    wr_idx_next = addr_ok ? a_idx : wr_idx_reg;
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 10'h0;
    end else begin
      wr_pend_reg <= wr_pend_next;
      wr_idx_reg <= wr_idx_next;
    end
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [15:0] pps_skew_reg, pps_skew_next;
  logic [15:0] nsl_reg, nsl_next, nsh_reg, nsh_next;
  logic [15:0] sl_reg, sl_next, sh_reg, sh_next;
  logic [15:0] cfg1_reg, cfg1_next, u12cfg2_reg, u12cfg2_next;
  logic [UNITS-1:0] en_reg, en_next, done_reg, done_next, mask_reg, mask_next;
  logic [UNITS-1:0] swrst_reg, swrst_next, unit_fire;
  logic fire;
  logic loop_mode;
  // the mask is kept at unit width; the word form only feeds the shared write helper
  logic [15:0] mask_word;

  function automatic logic [15:0] upd(input logic [15:0] cur, input logic [9:0] idx, input logic [15:0] m);
    upd = (wr_now && w_idx == idx) ? (wd & m) : cur;
  endfunction

  always_comb begin
    pps_skew_next = upd(pps_skew_reg, IDX_PPS_SKEW, PPS_SKEW_MASK);
    nsl_next = upd(nsl_reg, IDX_NSL, 16'hffff);
    nsh_next = upd(nsh_reg, IDX_NSH, NSH_MASK);
    sl_next = upd(sl_reg, IDX_SL, 16'hffff);
    sh_next = upd(sh_reg, IDX_SH, 16'hffff);
    cfg1_next = upd(cfg1_reg, IDX_CFG1, CFG1_MASK);
    u12cfg2_next = upd(u12cfg2_reg, IDX_U12_CFG2, 16'hffff);
    mask_word = upd({4'h0, mask_reg}, IDX_IRQ_MASK, UNIT_MASK);
    mask_next = mask_word[UNITS-1:0];
    // soft reset bits self-clear after one cycle
    swrst_next = (wr_now && w_idx == IDX_SWRST) ? wd[UNITS-1:0] : '0;
  end

  // per-unit enable and done; unit 1 is local, the rest report via UNIT_EVENT
  assign unit_fire = UNIT_EVENT | {{(UNITS-1){1'b0}}, fire};

  genvar g;
  generate
    for (g = 0; g < UNITS; g++) begin : g_unit
      logic hold;
      assign hold = (g == 0) && loop_mode;
      always_comb begin
        // a software write wins over the self-clear in the same cycle
        if (wr_now && w_idx == IDX_EN) begin
          en_next[g] = wd[g];
        end else if (swrst_reg[g] || (unit_fire[g] && !hold)) begin
          en_next[g] = 1'b0;
        end else begin
          en_next[g] = en_reg[g];
        end
        // set beats write-one-to-clear
        done_next[g] = (done_reg[g] && !(wr_now && w_idx == IDX_DONE && wd[g]))
          || (unit_fire[g] && (g != 0 || cfg1_reg[CFG_NOTIFY_BIT]));
      end
    end
  endgenerate

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      pps_skew_reg <= RST_WORD;
      nsl_reg <= RST_WORD;
      nsh_reg <= RST_WORD;
      sl_reg <= RST_WORD;
      sh_reg <= RST_WORD;
      cfg1_reg <= RST_WORD;
      u12cfg2_reg <= RST_WORD;
      en_reg <= '0;
      done_reg <= '0;
      mask_reg <= '0;
      swrst_reg <= '0;
    end else begin
      pps_skew_reg <= pps_skew_next;
      nsl_reg <= nsl_next;
      nsh_reg <= nsh_next;
      sl_reg <= sl_next;
      sh_reg <= sh_next;
      cfg1_reg <= cfg1_next;
      u12cfg2_reg <= u12cfg2_next;
      en_reg <= en_next;
      done_reg <= done_next;
      mask_reg <= mask_next;
      swrst_reg <= swrst_next;
    end
  end

  // ----------------------------------------------------------------
  // read mux works on next values so a read right after a write sees it
  // ----------------------------------------------------------------
  logic [15:0] rd_word;
  logic [31:0] hrdata_reg, hrdata_next;

  always_comb begin
    case (a_idx)
      IDX_DONE: rd_word = {4'h0, done_next};
      IDX_EN: rd_word = {4'h0, en_next};
      IDX_SWRST: rd_word = {4'h0, swrst_next};
      IDX_PPS_SKEW: rd_word = pps_skew_next;
      IDX_NSL: rd_word = nsl_next;
      IDX_NSH: rd_word = nsh_next;
      IDX_SL: rd_word = sl_next;
      IDX_SH: rd_word = sh_next;
      IDX_CFG1: rd_word = cfg1_next;
      IDX_U12_CFG2: rd_word = u12cfg2_next;
      IDX_IRQ_MASK: rd_word = {4'h0, mask_next};
      default: rd_word = 16'h0;
    endcase
    hrdata_next = (addr_ok && !HWRITE) ? {16'h0, rd_word} : 32'h0;
  end

  // ----------------------------------------------------------------
  // target compare with path-delay compensation
  // ----------------------------------------------------------------
  logic [30:0] skew_ns, tgt_ns_sum, tgt_ns;
  logic [31:0] tgt_sec;
  logic time_ge;

  always_comb begin
    // coarse steps stretch the same three bits to cover 0..28 ns
    skew_ns = 31'(pps_skew_reg[SKEW_LSB +: 3]) * (pps_skew_reg[SKEW_FINE_BIT] ? STEP_FINE_NS : STEP_COARSE_NS);
    tgt_ns_sum = {1'b0, nsh_reg[13:0], nsl_reg} + skew_ns;
    if (tgt_ns_sum >= NS_PER_SEC) begin
      tgt_ns = tgt_ns_sum - NS_PER_SEC;
      tgt_sec = {sh_reg, sl_reg} + 32'h1;
    end else begin
      tgt_ns = tgt_ns_sum;
      tgt_sec = {sh_reg, sl_reg};
    end
    time_ge = (PTP_SEC > tgt_sec) || (PTP_SEC == tgt_sec && {1'b0, PTP_NS} >= tgt_ns);
  end

  // ----------------------------------------------------------------
  // unit 1 sequencer
  // ----------------------------------------------------------------
  unit_state_t st_reg, st_next;
  logic trig_reg, irq_reg;

  // only unit 1 is local, so "no tail anywhere" is judged on unit 1 alone
  assign loop_mode = cfg1_reg[CFG_CASCADE_BIT] && !cfg1_reg[CFG_TAIL_BIT];
  assign fire = (st_reg == UNIT_ARMED) && en_reg[0] && time_ge && !swrst_reg[0];

  always_comb begin
    st_next = st_reg;
    case (st_reg)
      UNIT_IDLE: if (en_reg[0] && !swrst_reg[0]) st_next = UNIT_ARMED;
      UNIT_ARMED: begin
        if (swrst_reg[0] || !en_reg[0]) st_next = UNIT_IDLE;
        else if (fire) st_next = loop_mode ? UNIT_WAIT_LOW : UNIT_IDLE;
      end
      // in a loop, re-arm only after the time drops below target again
      UNIT_WAIT_LOW: begin
        if (swrst_reg[0] || !en_reg[0]) st_next = UNIT_IDLE;
        else if (!time_ge) st_next = UNIT_ARMED;
      end
      default: st_next = UNIT_IDLE;
    endcase
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      st_reg <= UNIT_IDLE;
      trig_reg <= 1'b0;
      irq_reg <= 1'b0;
      hrdata_reg <= 32'h0;
    end else begin
      st_reg <= st_next;
      trig_reg <= fire;
      irq_reg <= |(done_next & mask_next);
      hrdata_reg <= hrdata_next;
    end
  end

  assign TRIG1_OUT = trig_reg;
  assign IRQ = irq_reg;
  assign HRDATA = hrdata_reg;
  assign TRIGGER_UNIT_ENABLES_OUT = en_reg;
  assign SW_RST_OUT = swrst_reg;
  assign PPS12_WIDTH = {pps_skew_reg[7:0], u12cfg2_reg};

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  sequence wr_seq(logic [9:0] idx);
    wr_now && w_idx == idx;
  endsequence

  fire_done_a: assert property (fire && cfg1_reg[CFG_NOTIFY_BIT] |=> done_reg[0])
    else $error("done flag not set after notified fire");
  irq_follow_a: assert property ($rose(done_reg[0]) && mask_reg[0] |-> IRQ)
    else $error("interrupt did not follow unmasked done");
  self_clear_a: assert property (fire && !loop_mode && !(wr_now && w_idx == IDX_EN) |=> !en_reg[0])
    else $error("enable not cleared after single fire");
  loop_keep_a: assert property (fire && loop_mode && !(wr_now && w_idx == IDX_EN)
    |=> en_reg[0] && st_reg == UNIT_WAIT_LOW) else $error("looping unit lost its enable");
  fire_time_a: assert property (TRIG1_OUT |-> $past(time_ge) && $past(en_reg[0]))
    else $error("trigger fired before target time");
  ns_high_a: assert property (wr_seq(IDX_NSH) |=> nsh_reg == ($past(HWDATA[15:0]) & NSH_MASK))
    else $error("nanosecond high word wrong after write");
  sec_write_a: assert property (wr_seq(IDX_SH) |=> sh_reg == $past(HWDATA[15:0]))
    else $error("seconds high word not stored");
  cascade_a: assert property (wr_seq(IDX_CFG1) |=> cfg1_reg[CFG_CASCADE_BIT] == $past(HWDATA[15]))
    else $error("cascade bit not stored");
  pps_ext_a: assert property (wr_seq(IDX_PPS_SKEW) |=> PPS12_WIDTH[23:16] == $past(HWDATA[7:0]))
    else $error("pulse width extension not applied");
  skew_step_a: assert property (!pps_skew_reg[SKEW_FINE_BIT] && pps_skew_reg[10:8] == 3'h7
    |-> skew_ns == 31'h1c) else $error("coarse compensation not 28 ns at full scale");

  // ----------------------------------------------------------------
  // sequencing and storage checks
  // ----------------------------------------------------------------
  // a soft reset of unit 1 that no enable write in the same cycle overrides
  sequence soft_stop_seq;
    swrst_reg[0] && !(wr_now && w_idx == IDX_EN);
  endsequence
  // the pulse after a fire, then the quiet cycle that must follow it
  sequence pulse_once_seq;
    TRIG1_OUT ##1 !TRIG1_OUT;
  endsequence

  single_pulse_a: assert property (fire |=> pulse_once_seq)
    else $error("trigger pulse longer than one cycle");
  soft_stop_a: assert property (soft_stop_seq |=> !en_reg[0] ##1 st_reg == UNIT_IDLE)
    else $error("soft reset did not stop unit 1");
  // the interrupt is registered from the next done and mask values, so it never lags the unmasked done bits
  irq_level_a: assert property (IRQ == |(done_reg & mask_reg))
    else $error("interrupt level differs from unmasked done bits");
  done_clear_a: assert property (wr_now && w_idx == IDX_DONE && wd[0] && !unit_fire[0] |=> !done_reg[0])
    else $error("done flag not cleared by writing one");
  unit_done_a: assert property (UNIT_EVENT[UNITS-1] |=> done_reg[UNITS-1])
    else $error("unit 12 done flag not set by its event");
  unit_clear_a: assert property (UNIT_EVENT[UNITS-1] && !(wr_now && w_idx == IDX_EN) |=> !en_reg[UNITS-1])
    else $error("unit 12 enable not cleared by its event");
  ns_low_a: assert property (wr_seq(IDX_NSL) |=> nsl_reg == $past(HWDATA[15:0]))
    else $error("nanosecond low word not stored");
  sec_low_a: assert property (wr_seq(IDX_SL) |=> sl_reg == $past(HWDATA[15:0]))
    else $error("seconds low word not stored");
  ns_reserved_a: assert property (nsh_reg[15:14] == 2'h0)
    else $error("reserved nanosecond bits not zero");
  skew_fine_a: assert property (pps_skew_reg[SKEW_FINE_BIT] && pps_skew_reg[10:8] == 3'h7
    |-> skew_ns == 31'h7) else $error("fine compensation not 7 ns at full scale");

endmodule // ptp_trigger_target_time

// file: ptp_trigger_target_time_bench.sv
// self-checking bench for the unit 1 target-time trigger block
`timescale 1ns/1ps
module ptp_trigger_target_time_bench;
  import ptp_trig_pkg::*;
  // ----------------------------------------------------------------
  // signals and design
  // ----------------------------------------------------------------
  logic mclk, rst_n, hsel, hwrite;
  logic [31:0] haddr, hwdata, ptp_sec, seed, hrdata;
  logic [1:0] htrans;
  logic [29:0] ptp_ns;
  logic hreadyout, hresp, trig1_out, irq;
  logic [UNITS-1:0] trigger_unit_enables_out, sw_rst_out, unit_event;
  logic [23:0] pps12_width;
  wire hready = hreadyout;
  int failures, total_checks, f0;
  int fires = 0;
  ptp_trigger_target_time i_ptp_trigger_target_time (.MCLK(mclk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .PTP_SEC(ptp_sec), .PTP_NS(ptp_ns), .UNIT_EVENT(unit_event),
    .TRIG1_OUT(trig1_out), .TRIGGER_UNIT_ENABLES_OUT(trigger_unit_enables_out), .SW_RST_OUT(sw_rst_out), .PPS12_WIDTH(pps12_width),
    .IRQ(irq));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // pulses are counted so a stuck-high output shows up as extra fires
  always @(posedge mclk) if (trig1_out === 1'b1) fires <= fires + 1;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction
  function automatic logic [29:0] exp_target(input logic [15:0] base, input logic fine, input logic [2:0] code);
    return {14'h0, base} + {27'h0, code} * (fine ? 30'd1 : 30'd4);
  endfunction
  task automatic complete_run();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic guard(input int n);
    if (n >= 40) begin
      failures++;
      $display("BAD %0t wait ran out", $time);
      complete_run();
    end
  endtask
  // one single AHB-Lite transfer; read data taken at the data-phase edge
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [15:0] wd, output logic [15:0] rd);
    int n;
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    haddr <= {20'h0, idx, 2'b00};
    n = 0;
    do begin @(posedge mclk); n++; end while (hready !== 1'b1 && n < 40);
    guard(n);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0, wd};
    n = 0;
    do begin @(posedge mclk); n++; end while (hready !== 1'b1 && n < 40);
    guard(n);
    rd = hrdata[15:0];
  endtask
  task automatic wr(input logic [9:0] idx, input logic [15:0] d);
    logic [15:0] x;
    bus(1'b1, idx, d, x);
  endtask
  task automatic rdc(input logic [9:0] idx, input logic [15:0] exp);
    logic [15:0] x;
    bus(1'b0, idx, 16'h0, x);
    check({16'h0, x}, {16'h0, exp}, "register read");
  endtask
  // ----------------------------------------------------------------
  // trigger scenario: early time must not fire, compensated target must
  // ----------------------------------------------------------------
  task automatic fire_test(input logic fine, input logic [2:0] code, input logic loopm);
    logic [15:0] base;
    logic [29:0] tgt;
    int n;
    base = (rnd() >> 1) + 16'h0001;
    tgt = exp_target(base, fine, code);
    wr(IDX_NSL, base);
    wr(IDX_NSH, 16'h0000);
    wr(IDX_SL, 16'h0005);
    wr(IDX_SH, 16'h0000);
    wr(IDX_PPS_SKEW, {4'h0, fine, code, 8'h00});
    wr(IDX_CFG1, {loopm, 1'b0, 1'b1, 13'h0000});
    wr(IDX_IRQ_MASK, {15'h0, fine});
    ptp_sec <= 32'h5;
    ptp_ns <= tgt - 30'h1;
    f0 = fires;
    wr(IDX_EN, 16'h0001);
    repeat (6) @(negedge mclk);
    check(fires - f0, 0, "fired before target");
    @(posedge mclk);
    ptp_ns <= tgt;
    n = 0;
    while (fires == f0 && n < 40) begin @(negedge mclk); n++; end
    guard(n);
    repeat (3) @(negedge mclk);
    check(fires - f0, 1, "single pulse");
    check(trigger_unit_enables_out[0], loopm, "enable after fire");
    rdc(IDX_DONE, 16'h0001);
    @(negedge mclk);
    check(irq, fine, "irq vs mask");
    wr(IDX_DONE, 16'h0001);
    repeat (2) @(negedge mclk);
    check(irq, 1'b0, "irq after clear");
    rdc(IDX_DONE, 16'h0000);
    wr(IDX_SWRST, 16'h0001);
    repeat (2) @(negedge mclk);
    check(trigger_unit_enables_out[0], 1'b0, "enable after soft reset");
    $display("trigger test fine=%0d loop=%0d done", fine, loopm);
  endtask
  // units 2 to 12 only report through UNIT_EVENT; their enable, done and reset bits still follow the rules
  task automatic unit_test(input logic [3:0] u);
    logic [UNITS-1:0] b;
    b = {{(UNITS-1){1'b0}}, 1'b1} << u;
    wr(IDX_EN, {4'h0, b});
    @(posedge mclk);
    unit_event <= b;
    @(posedge mclk);
    unit_event <= '0;
    repeat (2) @(negedge mclk);
    check(trigger_unit_enables_out, 32'h0, "unit enable after event");
    rdc(IDX_DONE, {4'h0, b});
    wr(IDX_DONE, {4'h0, b});
    rdc(IDX_DONE, 16'h0000);
    wr(IDX_SWRST, {4'h0, b});
    @(negedge mclk);
    check(sw_rst_out, b, "soft reset pulse");
    @(negedge mclk);
    check(sw_rst_out, 32'h0, "soft reset self-clear");
    $display("unit event test unit=%0d done", u + 1);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] d, e;
    seed = 32'h4913;
    failures = 0;
    total_checks = 0;
    unit_event = '0;
    rst_n = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    ptp_sec = 32'h0;
    ptp_ns = 30'h0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    rdc(IDX_NSL, RST_WORD);
    rdc(IDX_NSH, RST_WORD);
    rdc(IDX_SL, RST_WORD);
    rdc(IDX_SH, RST_WORD);
    rdc(IDX_CFG1, RST_WORD);
    rdc(IDX_PPS_SKEW, RST_WORD);
    $display("reset value test done");
    for (int i = 0; i < 6; i++) begin
      d = rnd();
      if (i == 0) d = 16'hffff;
      wr(IDX_NSL, d);
      rdc(IDX_NSL, d);
      wr(IDX_NSH, d);
      rdc(IDX_NSH, d & NSH_MASK);
      wr(IDX_SL, ~d);
      rdc(IDX_SL, ~d);
      wr(IDX_SH, d);
      rdc(IDX_SH, d);
      wr(IDX_CFG1, d);
      rdc(IDX_CFG1, d & CFG1_MASK);
      wr(IDX_PPS_SKEW, d);
      rdc(IDX_PPS_SKEW, d & PPS_SKEW_MASK);
      e = rnd();
      wr(IDX_U12_CFG2, e);
      repeat (2) @(negedge mclk);
      check({8'h0, pps12_width}, {8'h0, d[7:0], e}, "pulse width");
      wr(10'h3ff, d);
      rdc(10'h3ff, 16'h0000);
    end
    wr(IDX_CFG1, 16'h0000);
    $display("register test done");
    d = rnd();
    fire_test(1'b1, d[2:0], 1'b0);
    fire_test(1'b0, 3'h7, 1'b0);
    d = rnd();
    fire_test(1'b1, d[2:0], 1'b1);
    unit_test(4'(1 + (rnd() % 11)));
    unit_test(4'hb);
    complete_run();
  end
endmodule // ptp_trigger_target_time_bench
